/* File: core/psimd_pkg.sv */
/*
 Package for the packed SIMD datapath: operation codes, lane widths,
 pipeline latency and lane constants.
 Assumes nothing of its surroundings.
*/
package psimd_pkg;
    localparam int PSIMD_DATA_W = 64;
    localparam int PSIMD_BYTE_W = 8;
    localparam int PSIMD_WORD_W = 16;
    localparam int PSIMD_DWORD_W = 32;
    localparam int PSIMD_NBYTE = 8;
    localparam int PSIMD_NWORD = 4;
    localparam int PSIMD_LATENCY = 2;
    localparam logic [63:0] PSIMD_RESULT_RESET = 64'h0;
    localparam logic PSIMD_VALID_RESET = 1'b0;
    localparam logic [15:0] PSIMD_WORD_SIGN = 16'h8000;

    typedef enum logic [4:0] {
        OP_MAX_SW,
        OP_MIN_SW,
        OP_MAX_UB,
        OP_MIN_UB,
        OP_MULH_UW,
        OP_MULH_SW,
        OP_SAD_UB,
        OP_AVG_UB,
        OP_AVG_UW,
        OP_MADD_SW,
        OP_ADDUS_B,
        OP_ADDUS_W,
        OP_SUBUS_B,
        OP_SUBUS_W,
        OP_ADDSS_B,
        OP_ADDSS_W,
        OP_SUBSS_B,
        OP_SUBSS_W,
        OP_ADD_B,
        OP_ADD_W,
        OP_SUB_B,
        OP_SUB_W
    } psimd_op_type;
endpackage

/* File: core/psimd_sad.sv */
/*
 Sum of absolute differences of eight unsigned byte pairs.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/10ps
module psimd_sad (
    input wire logic [63:0] opA,
    input wire logic [63:0] opB,
    output logic [15:0] sadSum
);
    import psimd_pkg::*;

    logic [7:0] absDiff [PSIMD_NBYTE];

    genvar i;
    generate
        for (i = 0; i < PSIMD_NBYTE; i++) begin : g_abs
            logic [7:0] a;
            logic [7:0] b;
            assign a = opA[i*8 +: 8];
            assign b = opB[i*8 +: 8];
            assign absDiff[i] = (a > b) ? 8'(a - b) : 8'(b - a);
        end
    endgenerate

    always_comb begin
        sadSum = 16'h0;
        for (int k = 0; k < PSIMD_NBYTE; k++) begin
            sadSum = 16'(sadSum + {8'h0, absDiff[k]});
        end
    end
endmodule

/* File: core/psimd_alu.sv */
/*
 Packed SIMD integer datapath, 64-bit operands split into byte or word
 lanes, with a two-stage pipeline (operands registered, then result).
 Assumes the decode stage presents op, opA (destination register) and
 opB (register or memory source) with inValid, all on the core clock.
*/
`timescale 1ns/10ps
module psimd_alu (
    input wire logic clock,
    input wire logic srst,
    input wire logic clockEnable,
    input wire logic inValid,
    input wire psimd_pkg::psimd_op_type op,
    input wire logic [63:0] opA,
    input wire logic [63:0] opB,
    output logic outValid,
    output logic [63:0] result
);
    import psimd_pkg::*;

    // Stage 1: operand capture
    logic s1Valid_reg, s1Valid_next;
    psimd_op_type s1Op_reg, s1Op_next;
    logic [63:0] s1A_reg, s1A_next;
    logic [63:0] s1B_reg, s1B_next;
    // Stage 2: result
    logic outValid_reg, outValid_next;
    logic [63:0] result_reg, result_next;

    logic [63:0] byteRes [OP_SUB_W+1];
    logic [63:0] wordRes [OP_SUB_W+1];
    logic [15:0] sadSum;

    always_comb begin
        s1Valid_next = inValid;
        s1Op_next = s1Op_reg;
        s1A_next = s1A_reg;
        s1B_next = s1B_reg;
        if (inValid) begin
            s1Op_next = op;
            s1A_next = opA;
            s1B_next = opB;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s1Valid_reg <= PSIMD_VALID_RESET;
            s1Op_reg <= OP_MAX_SW;
            s1A_reg <= PSIMD_RESULT_RESET;
            s1B_reg <= PSIMD_RESULT_RESET;
        end else if (clockEnable) begin
            s1Valid_reg <= s1Valid_next;
            s1Op_reg <= s1Op_next;
            s1A_reg <= s1A_next;
            s1B_reg <= s1B_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < PSIMD_NBYTE; i++) begin : g_byte
            logic [7:0] a;
            logic [7:0] b;
            logic [8:0] uSum;
            logic [8:0] uDif;
            logic [8:0] avg;
            logic signed [8:0] sSum;
            logic signed [8:0] sDif;
            assign a = s1A_reg[i*8 +: 8];
            assign b = s1B_reg[i*8 +: 8];
            assign uSum = {1'b0, a} + {1'b0, b};
            assign uDif = {1'b0, a} - {1'b0, b};
            assign avg = 9'({1'b0, a} + {1'b0, b} + 9'h1);
            assign sSum = 9'(signed'({a[7], a}) + signed'({b[7], b}));
            assign sDif = 9'(signed'({a[7], a}) - signed'({b[7], b}));
            assign byteRes[OP_MAX_UB][i*8 +: 8] = (a > b) ? a : b;
            assign byteRes[OP_MIN_UB][i*8 +: 8] = (a < b) ? a : b;
            assign byteRes[OP_AVG_UB][i*8 +: 8] = avg[8:1];
            assign byteRes[OP_ADDUS_B][i*8 +: 8] = uSum[8] ? 8'hff : uSum[7:0];
            assign byteRes[OP_SUBUS_B][i*8 +: 8] = uDif[8] ? 8'h00 : uDif[7:0];
            assign byteRes[OP_ADDSS_B][i*8 +: 8] =
                (sSum[8] != sSum[7]) ? (sSum[8] ? 8'h80 : 8'h7f) : sSum[7:0];
            assign byteRes[OP_SUBSS_B][i*8 +: 8] =
                (sDif[8] != sDif[7]) ? (sDif[8] ? 8'h80 : 8'h7f) : sDif[7:0];
            assign byteRes[OP_ADD_B][i*8 +: 8] = uSum[7:0];
            assign byteRes[OP_SUB_B][i*8 +: 8] = uDif[7:0];
        end
    endgenerate

    generate
        for (i = 0; i < PSIMD_NWORD; i++) begin : g_word
            logic [15:0] a;
            logic [15:0] b;
            logic [16:0] uSum;
            logic [16:0] uDif;
            logic [16:0] avg;
            logic signed [16:0] sSum;
            logic signed [16:0] sDif;
            logic [31:0] uProd;
            logic signed [31:0] sProd;
            assign a = s1A_reg[i*16 +: 16];
            assign b = s1B_reg[i*16 +: 16];
            assign uSum = {1'b0, a} + {1'b0, b};
            assign uDif = {1'b0, a} - {1'b0, b};
            assign avg = 17'({1'b0, a} + {1'b0, b} + 17'h1);
            assign sSum = 17'(signed'({a[15], a}) + signed'({b[15], b}));
            assign sDif = 17'(signed'({a[15], a}) - signed'({b[15], b}));
            assign uProd = 32'(a) * 32'(b);
            assign sProd = 32'(signed'(a)) * 32'(signed'(b));
            assign wordRes[OP_MAX_SW][i*16 +: 16] = (signed'(a) > signed'(b)) ? a : b;
            assign wordRes[OP_MIN_SW][i*16 +: 16] = (signed'(a) < signed'(b)) ? a : b;
            assign wordRes[OP_MULH_UW][i*16 +: 16] = uProd[31:16];
            assign wordRes[OP_MULH_SW][i*16 +: 16] = sProd[31:16];
            assign wordRes[OP_AVG_UW][i*16 +: 16] = avg[16:1];
            assign wordRes[OP_ADDUS_W][i*16 +: 16] = uSum[16] ? 16'hffff : uSum[15:0];
            assign wordRes[OP_SUBUS_W][i*16 +: 16] = uDif[16] ? 16'h0000 : uDif[15:0];
            assign wordRes[OP_ADDSS_W][i*16 +: 16] = (sSum[16] != sSum[15]) ?
                (sSum[16] ? PSIMD_WORD_SIGN : 16'h7fff) : sSum[15:0];
            assign wordRes[OP_SUBSS_W][i*16 +: 16] = (sDif[16] != sDif[15]) ?
                (sDif[16] ? PSIMD_WORD_SIGN : 16'h7fff) : sDif[15:0];
            assign wordRes[OP_ADD_W][i*16 +: 16] = uSum[15:0];
            assign wordRes[OP_SUB_W][i*16 +: 16] = uDif[15:0];
        end
    endgenerate

    logic signed [31:0] madProd [PSIMD_NWORD];
    generate
        for (i = 0; i < PSIMD_NWORD; i++) begin : g_mad
            assign madProd[i] = 32'(signed'(s1A_reg[i*16 +: 16]))
                * 32'(signed'(s1B_reg[i*16 +: 16]));
        end
    endgenerate

    psimd_sad i_psimd_sad (
        .opA(s1A_reg),
        .opB(s1B_reg),
        .sadSum(sadSum)
    );

    always_comb begin
        outValid_next = s1Valid_reg;
        result_next = result_reg;
        if (s1Valid_reg) begin
            case (s1Op_reg)
                OP_MAX_SW: result_next = wordRes[OP_MAX_SW];
                OP_MIN_SW: result_next = wordRes[OP_MIN_SW];
                OP_MAX_UB: result_next = byteRes[OP_MAX_UB];
                OP_MIN_UB: result_next = byteRes[OP_MIN_UB];
                OP_MULH_UW: result_next = wordRes[OP_MULH_UW];
                OP_MULH_SW: result_next = wordRes[OP_MULH_SW];
                OP_SAD_UB: result_next = {48'h0, sadSum};
                OP_AVG_UB: result_next = byteRes[OP_AVG_UB];
                OP_AVG_UW: result_next = wordRes[OP_AVG_UW];
                OP_MADD_SW: result_next = {32'(madProd[3] + madProd[2]),
                                           32'(madProd[1] + madProd[0])};
                OP_ADDUS_B: result_next = byteRes[OP_ADDUS_B];
                OP_ADDUS_W: result_next = wordRes[OP_ADDUS_W];
                OP_SUBUS_B: result_next = byteRes[OP_SUBUS_B];
                OP_SUBUS_W: result_next = wordRes[OP_SUBUS_W];
                OP_ADDSS_B: result_next = byteRes[OP_ADDSS_B];
                OP_ADDSS_W: result_next = wordRes[OP_ADDSS_W];
                OP_SUBSS_B: result_next = byteRes[OP_SUBSS_B];
                OP_SUBSS_W: result_next = wordRes[OP_SUBSS_W];
                OP_ADD_B: result_next = byteRes[OP_ADD_B];
                OP_ADD_W: result_next = wordRes[OP_ADD_W];
                OP_SUB_B: result_next = byteRes[OP_SUB_B];
                OP_SUB_W: result_next = wordRes[OP_SUB_W];
                default: result_next = PSIMD_RESULT_RESET;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            outValid_reg <= PSIMD_VALID_RESET;
            result_reg <= PSIMD_RESULT_RESET;
        end else if (clockEnable) begin
            outValid_reg <= outValid_next;
            result_reg <= result_next;
        end
    end

    assign outValid = outValid_reg;
    assign result = result_reg;

    // Checks: op and operands behind the result now standing
    logic doneValid_reg, doneValid_next;
    psimd_op_type doneOp_reg;
    logic [63:0] doneA_reg;
    logic [63:0] doneB_reg;

    always_comb begin
        doneValid_next = !srst && clockEnable && s1Valid_reg;
    end

    always_ff @(posedge clock) begin
        doneValid_reg <= doneValid_next;
        doneOp_reg <= s1Op_reg;
        doneA_reg <= s1A_reg;
        doneB_reg <= s1B_reg;
    end

    max_sw_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_MAX_SW
        |-> signed'(result[15:0]) >= signed'(doneA_reg[15:0])
            && signed'(result[15:0]) >= signed'(doneB_reg[15:0])
            && (result[15:0] == doneA_reg[15:0] || result[15:0] == doneB_reg[15:0]))
        else $error("signed word max wrong");
    min_sw_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_MIN_SW
        |-> signed'(result[15:0]) <= signed'(doneA_reg[15:0])
            && signed'(result[15:0]) <= signed'(doneB_reg[15:0])
            && (result[15:0] == doneA_reg[15:0] || result[15:0] == doneB_reg[15:0]))
        else $error("signed word min wrong");
    max_ub_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_MAX_UB
        |-> result[7:0] >= doneA_reg[7:0] && result[7:0] >= doneB_reg[7:0]
            && (result[7:0] == doneA_reg[7:0] || result[7:0] == doneB_reg[7:0]))
        else $error("unsigned byte max wrong");
    min_ub_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_MIN_UB
        |-> result[7:0] <= doneA_reg[7:0] && result[7:0] <= doneB_reg[7:0]
            && (result[7:0] == doneA_reg[7:0] || result[7:0] == doneB_reg[7:0]))
        else $error("unsigned byte min wrong");
    mulh_uw_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_MULH_UW
        |-> result[15:0] == 16'((32'(doneA_reg[15:0]) * 32'(doneB_reg[15:0])) >> 16))
        else $error("unsigned multiply high wrong");
    sad_upper_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_SAD_UB
        |-> result[63:16] == 48'h0)
        else $error("sum of differences upper words not zero");
    avg_byte_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_AVG_UB
        |-> result[63:56] == 8'((9'(doneA_reg[63:56]) + 9'(doneB_reg[63:56]) + 9'h1) >> 1))
        else $error("byte average wrong");
    avg_word_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_AVG_UW
        |-> result[15:0] == 16'((17'(doneA_reg[15:0]) + 17'(doneB_reg[15:0]) + 17'h1) >> 1))
        else $error("word average wrong");
    madd_low_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_MADD_SW
        |-> result[31:0] == 32'(32'(signed'(doneA_reg[15:0])) * 32'(signed'(doneB_reg[15:0]))
            + 32'(signed'(doneA_reg[31:16])) * 32'(signed'(doneB_reg[31:16]))))
        else $error("multiply-add low pair wrong");
    addus_w_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_ADDUS_W
        |-> result[15:0] == ((17'(doneA_reg[15:0]) + 17'(doneB_reg[15:0]) > 17'h0ffff)
            ? 16'hffff : 16'(doneA_reg[15:0] + doneB_reg[15:0])))
        else $error("unsigned saturating add wrong");
    subss_neg_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_SUBSS_W && doneB_reg[15]
        |-> signed'(result[15:0]) >= signed'(doneA_reg[15:0]))
        else $error("negative subtrahend decreased result");
    add_w_a: assert property (@(posedge clock) disable iff (srst)
        doneValid_reg && doneOp_reg == OP_ADD_W
        |-> result[15:0] == 16'(doneA_reg[15:0] + doneB_reg[15:0]))
        else $error("wrapping word add wrong");
    latency_a: assert property (@(posedge clock) disable iff (srst)
        clockEnable && inValid ##1 clockEnable |=> outValid)
        else $error("result not valid after two cycles");

    sad_c: cover property (@(posedge clock) outValid && $past(s1Op_reg) == OP_SAD_UB);
    madd_c: cover property (@(posedge clock) outValid && $past(s1Op_reg) == OP_MADD_SW);
    sat_c: cover property (@(posedge clock) outValid && $past(s1Op_reg) == OP_SUBSS_W);
    b2b_c: cover property (@(posedge clock) outValid ##1 outValid);
    freeze_c: cover property (@(posedge clock) !clockEnable && s1Valid_reg);
endmodule

/* File: test/psimd_host_model.sv */
/*
 Behavioural model of the decode stage and SIMD register file that feed
 the packed SIMD datapath.
 Assumes the datapath samples its request on the rising clock edge.
*/
`timescale 1ns/10ps
module psimd_host_model (
    input wire logic clock,
    output logic inValid,
    output psimd_pkg::psimd_op_type op,
    output logic [63:0] opA,
    output logic [63:0] opB
);
    import psimd_pkg::*;

    initial begin
        inValid = 1'b0;
        op = OP_MAX_SW;
        opA = 64'h0;
        opB = 64'h0;
    end

    // one request per cycle, source from register or memory
    task automatic send(input psimd_op_type sendOp, input logic [63:0] a,
            input logic [63:0] b, input logic last);
        @(negedge clock);
        inValid = 1'b1;
        op = sendOp;
        opA = a;
        opB = b;
        if (last) begin
            @(negedge clock);
            inValid = 1'b0;
            // Released operands do not keep their last value
            opA = ~opA;
            opB = ~opB;
        end
    endtask
endmodule

/* File: test/psimd_alu_test.sv */
/*
 Self-checking testbench for the packed SIMD datapath.
 Assumes the host model drives requests after falling clock edges.
*/
`timescale 1ns/10ps
module psimd_alu_test;
    import psimd_pkg::*;

    logic clock = 1'b0;
    logic srst = 1'b1;
    logic clockEnable = 1'b1;
    logic inValid;
    psimd_op_type op;
    logic [63:0] opA;
    logic [63:0] opB;
    logic outValid;
    logic [63:0] result;
    int errors = 0;
    int n_compared = 0;

    always #12.5 clock = ~clock;

    psimd_host_model i_psimd_host_model (.clock(clock), .inValid(inValid), .op(op),
        .opA(opA), .opB(opB));

    psimd_alu i_psimd_alu (.clock(clock), .srst(srst), .clockEnable(clockEnable),
        .inValid(inValid), .op(op), .opA(opA), .opB(opB), .outValid(outValid),
        .result(result));

    task automatic conclude;
        $display("Counts: errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic checkResult(input logic [63:0] exp);
        n_compared++;
        if (result !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t result %h expected %h", $time, result, exp);
        end
    endtask

    task automatic checkValid(input logic exp);
        n_compared++;
        if (outValid !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t outValid %b expected %b", $time, outValid, exp);
        end
    endtask

    task automatic run(input psimd_op_type o, input logic [63:0] a, b, exp);
        i_psimd_host_model.send(o, a, b, 1'b1);
        @(negedge clock);
        checkValid(1'b1);
        checkResult(exp);
    endtask

    task automatic testMinMax;
        run(OP_MAX_SW, 64'h8000_7fff_0001_ffff, 64'h7fff_8000_ffff_0001,
            64'h7fff_7fff_0001_0001);
        run(OP_MIN_SW, 64'h8000_7fff_0001_ffff, 64'h7fff_8000_ffff_0001,
            64'h8000_8000_ffff_ffff);
        run(OP_MAX_UB, 64'h8000_7fff_0001_ffff, 64'h7fff_8000_ffff_0001,
            64'h80ff_80ff_ffff_ffff);
        run(OP_MIN_UB, 64'h8000_7fff_0001_ffff, 64'h7fff_8000_ffff_0001,
            64'h7f00_7f00_0001_0001);
    endtask

    task automatic testMulh;
        run(OP_MULH_UW, 64'hffff_8000_7fff_0002, 64'hffff_8000_7fff_8000,
            64'hfffe_4000_3fff_0001);
        run(OP_MULH_SW, 64'hffff_8000_7fff_0002, 64'hffff_8000_7fff_8000,
            64'h0000_4000_3fff_ffff);
    endtask

    task automatic testSadMadd;
        run(OP_SAD_UB, 64'hff00_ff00_0102_0304, 64'h00ff_00ff_0403_0201,
            64'h0000_0000_0000_0404);
        run(OP_MADD_SW, 64'h8000_8000_0003_fffe, 64'h8000_8000_0004_0005,
            64'h8000_0000_0000_0002);
    endtask

    task automatic testAvg;
        run(OP_AVG_UB, 64'hffff_0001_0100_8000, 64'hffff_0002_0000_8001,
            64'hffff_0002_0100_8001);
        run(OP_AVG_UW, 64'hffff_0001_0100_8000, 64'hffff_0002_0000_8001,
            64'hffff_0002_0080_8001);
    endtask

    task automatic testSaturate;
        run(OP_ADDUS_W, 64'hfff0_0001_8000_0000, 64'h0020_0002_8000_0000,
            64'hffff_0003_ffff_0000);
        run(OP_SUBUS_W, 64'hfff0_0001_8000_0000, 64'h0020_0002_8000_0000,
            64'hffd0_0000_0000_0000);
        run(OP_ADDUS_B, 64'hf001_8000_ff10_0001, 64'h2002_8000_0110_00fe,
            64'hff03_ff00_ff20_00ff);
        run(OP_SUBUS_B, 64'hf001_8000_ff10_0001, 64'h2002_8000_0110_00fe,
            64'hd000_0000_fe00_0000);
        run(OP_ADDSS_W, 64'h7fff_8000_0001_fff0, 64'h0001_ffff_0002_0005,
            64'h7fff_8000_0003_fff5);
        run(OP_SUBSS_W, 64'h7ff0_8000_0005_0000, 64'hfff0_0001_fffe_8000,
            64'h7fff_8000_0007_7fff);
        run(OP_ADDSS_B, 64'h7f80_01f0_0000_0000, 64'h01ff_0205_0000_0000,
            64'h7f80_03f5_0000_0000);
        run(OP_SUBSS_B, 64'h7f80_0500_0000_0000, 64'h8001_fe80_0000_0000,
            64'h7f80_077f_0000_0000);
    endtask

    task automatic testWrap;
        run(OP_ADD_W, 64'h0000_7fff_8000_ffff, 64'h8000_8000_8000_8000,
            64'h8000_ffff_0000_7fff);
        run(OP_ADD_B, 64'hff01_ff01_0000_0000, 64'h0101_0101_0000_0000,
            64'h0002_0002_0000_0000);
        run(OP_SUB_B, 64'h0000_0000_0000_0100, 64'h0000_0000_0000_0001,
            64'h0000_0000_0000_01ff);
        run(OP_SUB_W, 64'h0000_0000_ffff_0000, 64'h0000_0000_0001_0001,
            64'h0000_0000_fffe_ffff);
    endtask

    task automatic testPipe;
        i_psimd_host_model.send(OP_ADD_W, 64'h1, 64'h2, 1'b0);
        i_psimd_host_model.send(OP_SUB_W, 64'h5, 64'h3, 1'b1);
        checkValid(1'b1);
        checkResult(64'h3);
        @(negedge clock);
        checkValid(1'b1);
        checkResult(64'h2);
        @(negedge clock);
        checkValid(1'b0);
        i_psimd_host_model.send(OP_MAX_UB, 64'h10, 64'h20, 1'b1);
        clockEnable = 1'b0;
        repeat (3) @(negedge clock);
        checkValid(1'b0);
        checkResult(64'h2);
        clockEnable = 1'b1;
        @(negedge clock);
        checkValid(1'b1);
        checkResult(64'h20);
    endtask

    task automatic testReset;
        i_psimd_host_model.send(OP_ADD_B, 64'h01, 64'h02, 1'b1);
        srst = 1'b1;
        clockEnable = 1'b0;
        @(negedge clock);
        checkValid(PSIMD_VALID_RESET);
        checkResult(PSIMD_RESULT_RESET);
        srst = 1'b0;
        clockEnable = 1'b1;
        run(OP_ADD_B, 64'h01, 64'h02, 64'h03);
    endtask

    initial begin
        #50000;
        errors++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        conclude();
    end

    initial begin
        repeat (20) @(negedge clock);
        checkValid(PSIMD_VALID_RESET);
        checkResult(PSIMD_RESULT_RESET);
        srst = 1'b0;
        testMinMax();
        testMulh();
        testSadMadd();
        testAvg();
        testSaturate();
        testWrap();
        testPipe();
        testReset();
        conclude();
    end
endmodule
